// File: hdl/clk_pwr_pkg.sv
// Shared constants and types for the clock, power and reset controller
package clk_pwr_pkg;
  // Clock divide codes, clocks per machine cycle
  localparam logic [1:0] DIV_RSVD = 2'h0;
  localparam logic [1:0] DIV_4    = 2'h1;
  localparam logic [1:0] DIV_64   = 2'h2;
  localparam logic [1:0] DIV_1024 = 2'h3;
  localparam logic [1:0] DIV_RST  = DIV_4;
  localparam int CPC_4    = 4;
  localparam int CPC_64   = 64;
  localparam int CPC_1024 = 1024;
  localparam int CPC_W    = 10;
  // Watchdog reset delay after the timeout flag, in clocks
  localparam int WDT_DELAY_CLKS = 512;
  localparam int WDT_W          = 10;
  // Reset hold and extension, in machine cycles
  localparam logic [1:0] RST_EXT_CYCLES = 2'h2;
  localparam logic [1:0] WDT_HOLD_CYCLES = 2'h2;
  // Crystal warm-up default, in clocks
  localparam int XTAL_WARM_CLKS = 1024;
  // Power states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_PDOWN,
    ST_WAKE
  } pwr_state_type;
endpackage

// File: hdl/clock_power_reset_control.sv
// Clock divider, oscillator select, power-down and reset control
// Operation
// - Divide code 01 gives 4, 10 gives 64, 11 gives 1024; 00 reserved.
// - New divide or source selection applies one machine cycle after write.
// - Slow rates are entered only from divide-by-4; slow to slow refused.
// - Source select bit picks crystal or internal RC oscillator.
// - Crystal amplifier disabled when crystal-off set and RC is source.
// - Status bit shows which oscillator drives the system clock.
// - Crystal-ready flag sets once the crystal has warmed up.
// - Selecting crystal while crystal-ready is 0 is refused.
// - Switchback forces divide-by-4 on serial activity or taken interrupt.
// - Receive switchback on start-bit falling edge, only if receive enabled.
// - Transmit switchback when a byte is written to the transmit buffer.
// - Switchback does not depend on serial interrupt flags.
// - Divide writes ignored during serial transfer while switchback enabled.
// - Watchdog, power-on or external reset forces divide-by-4.
// - Power-down bit write stops all clocks after that instruction.
// - In power-down strobes driven low; port 0 floats if memory external.
// - High reset pin ends power-down and restarts from address zero.
// - Enabled level-mode low interrupt pin wakes power-down into its handler.
// - RC-wake select leaves power-down on RC, then moves to crystal.
// - Reset pin sampled at fourth state; pin held high two cycles.
// - Reset held while pin high and two machine cycles after release.
// - Watchdog reset fires 512 clocks after timeout, held two cycles.
`timescale 1ns/1ns
module clock_power_reset_control
  import clk_pwr_pkg::*;
#(
  parameter int XTAL_WARM = XTAL_WARM_CLKS,  // Crystal warm-up clocks
  parameter int IRQ_N     = 2                // External interrupt pins
) (
  input  wire logic             sys_clk_in,    // System clock
  input  wire logic             rst_in,        // Power-on reset
  input  wire logic             rst_pin_in,    // External reset pin
  input  wire logic             div_wr_in,     // Divide field write
  input  wire logic [1:0]       div_sel_in,    // Divide field value
  input  wire logic             switchback_enable_in, // Switchback on
  input  wire logic             src_wr_in,     // Source select write
  input  wire logic             clock_source_select_in, // 1 crystal
  input  wire logic             crystal_amp_off_in, // Crystal off
  input  wire logic             rc_wake_select_in, // Wake on RC
  input  wire logic             serial_rx_en_in, // Receive enabled
  input  wire logic             serial_rx_in,  // Receive line
  input  wire logic             sbuf_wr_in,    // Transmit buffer write
  input  wire logic             serial_busy_in, // Transfer running
  input  wire logic             irq_ack_in,    // Ext interrupt taken
  input  wire logic             irq_blocked_in, // Ack blocked
  input  wire logic [IRQ_N-1:0] ext_irq_n_in,  // Interrupt pins
  input  wire logic [IRQ_N-1:0] irq_enable_in, // Per-pin enables
  input  wire logic [IRQ_N-1:0] irq_level_in,  // Level detect mode
  input  wire logic             global_irq_enable_in, // Global enable
  input  wire logic             ext_prog_mem_in, // External program
  input  wire logic             power_down_wr_in, // Power-down write
  input  wire logic             wdt_rst_en_in, // Watchdog reset on
  input  wire logic             wdt_timeout_in, // Timeout flag set
  input  wire logic             wdt_clear_in,  // Watchdog cleared
  output logic [1:0]            div_code_out,  // Active divide code
  output logic                  machine_tick_out, // Cycle end
  output logic                  fourth_state_out, // Fourth state
  output logic                  rc_active_status_out, // RC running
  output logic                  crystal_ready_flag_out, // Warm
  output logic                  crystal_amp_en_out, // Amp enabled
  output logic                  clocks_run_out, // Core clocks on
  output logic                  strobes_low_out, // Strobes held low
  output logic                  port0_float_out, // Port 0 floats
  output logic                  sys_reset_out, // Internal reset
  output logic                  restart_zero_out, // Run from zero
  output logic                  wake_irq_out   // Resume to handler
);
  localparam int WARM_W = $clog2(XTAL_WARM + 1);

  pwr_state_type    state_reg;
  pwr_state_type    state_next;
  logic [1:0]       div_reg;
  logic [1:0]       div_pend_reg;
  logic             div_pend_valid_reg;
  logic             src_pend_reg;
  logic             src_pend_valid_reg;
  logic             rc_active_reg;
  logic             auto_xtal_reg;
  logic [WARM_W-1:0] warm_reg;
  logic             ready_reg;
  logic             rx_prev_reg;
  logic             ext_hold_reg;
  logic [1:0]       ext_cnt_reg;
  logic             wdt_arm_reg;
  logic [WDT_W-1:0] wdt_cnt_reg;
  logic [1:0]       wdt_hold_reg;
  logic             reset_reg;
  logic             tick;
  logic             fourth;
  logic             run;
  logic             amp_en;
  logic             sb_trig;
  logic             div_ok;
  logic             wake_req;
  logic             wdt_fire;
  logic             reset_next;
  logic             rst_any;

  assign run     = (state_reg == ST_RUN);
  assign rst_any = rst_in || reset_reg;

  machine_cycle_timer u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .run_in     (run),
    .div_in     (div_reg),
    .tick_out   (tick),
    .fourth_out (fourth)
  );

  // Switchback triggers, blind to serial interrupt flags
  assign sb_trig = switchback_enable_in &&
                   ((serial_rx_en_in && rx_prev_reg &&
                     !serial_rx_in) ||
                    sbuf_wr_in ||
                    (irq_ack_in && !irq_blocked_in &&
                     global_irq_enable_in));

  // Divide write legality
  assign div_ok = !(switchback_enable_in && serial_busy_in) &&
                  (div_sel_in != DIV_RSVD) &&
                  (div_sel_in == DIV_4 || div_reg == DIV_4);

  // Receive line history for start-bit edge
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= serial_rx_in;
    end
  end

  // Clock divide field with one-cycle deferred update
  always_ff @(posedge sys_clk_in) begin
    if (rst_any) begin
      div_reg            <= DIV_RST;
      div_pend_reg       <= DIV_RST;
      div_pend_valid_reg <= 1'b0;
    end else if (sb_trig) begin
      div_reg            <= DIV_4;
      div_pend_valid_reg <= 1'b0;
    end else if (tick && div_pend_valid_reg) begin
      div_reg            <= div_pend_reg;
      div_pend_valid_reg <= 1'b0;
    end else if (div_wr_in && div_ok && run) begin
      div_pend_reg       <= div_sel_in;
      div_pend_valid_reg <= 1'b1;
    end
  end

  // Crystal amplifier: off in power-down or when crystal-off is set and RC is the source
  assign amp_en = (state_reg != ST_PDOWN) &&
                  !(crystal_amp_off_in && rc_active_reg);

  // Crystal warm-up tracking
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !amp_en) begin
      warm_reg  <= '0;
      ready_reg <= 1'b0;
    end else if (warm_reg == WARM_W'(XTAL_WARM - 1)) begin
      ready_reg <= 1'b1;
    end else begin
      warm_reg  <= warm_reg + WARM_W'(1);
    end
  end

  // Clock source selection, deferred one machine cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_any) begin
      src_pend_reg       <= 1'b1;
      src_pend_valid_reg <= 1'b0;
      rc_active_reg      <= 1'b0;
      auto_xtal_reg      <= 1'b0;
    end else if (state_reg != ST_RUN && state_next == ST_RUN &&
                 rc_wake_select_in) begin
      rc_active_reg      <= 1'b1;
      auto_xtal_reg      <= 1'b1;
      src_pend_valid_reg <= 1'b0;
    end else if (auto_xtal_reg && ready_reg) begin
      rc_active_reg      <= 1'b0;
      auto_xtal_reg      <= 1'b0;
    end else if (tick && src_pend_valid_reg) begin
      rc_active_reg      <= !src_pend_reg;
      src_pend_valid_reg <= 1'b0;
    end else if (src_wr_in && run &&
                 (!clock_source_select_in || ready_reg)) begin
      src_pend_reg       <= clock_source_select_in;
      src_pend_valid_reg <= 1'b1;
    end
  end

  // Level-mode wake request from enabled interrupt pins
  assign wake_req = global_irq_enable_in &&
                    |(~ext_irq_n_in & irq_enable_in & irq_level_in);

  // Power state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (power_down_wr_in && !rst_any) begin
          state_next = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (rst_pin_in) begin
          state_next = ST_RUN;
        end else if (wake_req) begin
          state_next = rc_wake_select_in ? ST_RUN : ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (ready_reg || rst_pin_in) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // External reset: fourth-state sampling, two-cycle extension
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ext_hold_reg <= 1'b0;
      ext_cnt_reg  <= '0;
    end else if (rst_pin_in && (fourth || state_reg != ST_RUN)) begin
      ext_hold_reg <= 1'b1;
      ext_cnt_reg  <= RST_EXT_CYCLES;
    end else if (ext_hold_reg && tick) begin
      if (ext_cnt_reg == 2'h1) begin
        ext_hold_reg <= 1'b0;
      end
      ext_cnt_reg  <= ext_cnt_reg - 2'h1;
    end
  end

  // Watchdog reset delay and hold; no effect while clocks stopped
  assign wdt_fire = wdt_arm_reg &&
                    (wdt_cnt_reg == WDT_W'(WDT_DELAY_CLKS - 1));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !run || wdt_clear_in) begin
      wdt_arm_reg <= 1'b0;
      wdt_cnt_reg <= '0;
    end else if (wdt_timeout_in && wdt_rst_en_in && !wdt_arm_reg) begin
      wdt_arm_reg <= 1'b1;
      wdt_cnt_reg <= '0;
    end else if (wdt_fire) begin
      wdt_arm_reg <= 1'b0;
    end else if (wdt_arm_reg) begin
      wdt_cnt_reg <= wdt_cnt_reg + WDT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wdt_hold_reg <= '0;
    end else if (wdt_fire) begin
      wdt_hold_reg <= WDT_HOLD_CYCLES;
    end else if (wdt_hold_reg != 2'h0 && tick) begin
      wdt_hold_reg <= wdt_hold_reg - 2'h1;
    end
  end

  // Combined internal reset
  assign reset_next = rst_in || ext_hold_reg || rst_pin_in &&
                      state_reg != ST_RUN || wdt_fire ||
                      wdt_hold_reg != 2'h0;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reset_reg        <= 1'b1;
      restart_zero_out <= 1'b0;
    end else begin
      reset_reg        <= reset_next;
      restart_zero_out <= reset_reg && !reset_next;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      div_code_out           <= DIV_RST;
      machine_tick_out       <= 1'b0;
      fourth_state_out       <= 1'b0;
      rc_active_status_out   <= 1'b0;
      crystal_ready_flag_out <= 1'b0;
      crystal_amp_en_out     <= 1'b1;
      clocks_run_out         <= 1'b1;
      strobes_low_out        <= 1'b0;
      port0_float_out        <= 1'b0;
      sys_reset_out          <= 1'b1;
      wake_irq_out           <= 1'b0;
    end else begin
      div_code_out           <= div_reg;
      machine_tick_out       <= tick;
      fourth_state_out       <= fourth;
      rc_active_status_out   <= rc_active_reg;
      crystal_ready_flag_out <= ready_reg;
      crystal_amp_en_out     <= amp_en;
      clocks_run_out         <= run;
      strobes_low_out        <= !run;
      port0_float_out        <= !run && ext_prog_mem_in;
      sys_reset_out          <= reset_reg;
      wake_irq_out           <= state_reg != ST_RUN &&
                                state_next == ST_RUN &&
                                !rst_pin_in;
    end
  end

  // Checks
  AST_DIV_NEVER_RSVD: assert property (@(posedge sys_clk_in)
    disable iff (rst_in) div_reg != DIV_RSVD)
    else $error("reserved divide code active");

  AST_NO_SLOW_TO_SLOW: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    ($past(div_reg) != DIV_4 && div_reg != $past(div_reg))
    |-> div_reg == DIV_4)
    else $error("direct move between slow rates");

  AST_DEFER_ONE_CYCLE: assert property (@(posedge sys_clk_in)
    disable iff (rst_any)
    (div_wr_in && div_ok && run && !sb_trig &&
     !div_pend_valid_reg && !tick && div_sel_in != div_reg)
    |=> div_reg == $past(div_reg))
    else $error("divide change applied before cycle end");

  AST_SWITCHBACK: assert property (@(posedge sys_clk_in)
    disable iff (rst_any) sb_trig |=> div_reg == DIV_4)
    else $error("switchback did not force divide by 4");

  AST_RESET_DIV4: assert property (@(posedge sys_clk_in)
    reset_reg |=> div_reg == DIV_4)
    else $error("reset did not restore divide by 4");

  AST_XTAL_NEEDS_READY: assert property (@(posedge sys_clk_in)
    disable iff (rst_any)
    $fell(rc_active_reg) |-> $past(ready_reg))
    else $error("crystal selected before ready");

  AST_AMP_OFF: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (crystal_amp_off_in && rc_active_reg) |-> !amp_en)
    else $error("crystal amplifier left on");

  AST_PD_STROBES: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (state_reg == ST_PDOWN) |=> strobes_low_out)
    else $error("strobes not low in power-down");

  AST_PD_EXIT_RST: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (state_reg == ST_PDOWN && rst_pin_in)
    |=> state_reg == ST_RUN ##1 reset_reg)
    else $error("reset pin did not end power-down");

  // Clocks since arming, counted apart from the watchdog counter
  logic [WDT_W:0] wdt_age_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !run || wdt_clear_in || wdt_fire) begin
      wdt_age_reg <= '0;
    end else if (wdt_timeout_in && wdt_rst_en_in && !wdt_arm_reg) begin
      wdt_age_reg <= (WDT_W+1)'(1);
    end else if (wdt_age_reg != '0) begin
      wdt_age_reg <= wdt_age_reg + (WDT_W+1)'(1);
    end
  end

  AST_WDT_512: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    (wdt_age_reg == (WDT_W+1)'(WDT_DELAY_CLKS)) == wdt_fire)
    else $error("watchdog reset not 512 clocks after timeout");

  AST_EXT_EXTEND: assert property (@(posedge sys_clk_in)
    disable iff (rst_in)
    $fell(rst_pin_in) && ext_hold_reg && run |=> reset_reg)
    else $error("external reset released early");

  COV_SLOW_MODE: cover property (@(posedge sys_clk_in)
    div_reg == DIV_1024);
  COV_SWITCHBACK: cover property (@(posedge sys_clk_in)
    sb_trig && div_reg != DIV_4);
  COV_IRQ_WAKE: cover property (@(posedge sys_clk_in)
    state_reg == ST_PDOWN && wake_req);
  COV_WDT_RESET: cover property (@(posedge sys_clk_in) wdt_fire);
endmodule

// File: hdl/machine_cycle_timer.sv
// Machine cycle divider: cycle end tick and fourth-state strobe
`timescale 1ns/1ns
module machine_cycle_timer
  import clk_pwr_pkg::*;
(
  input  wire logic       sys_clk_in,  // System clock
  input  wire logic       rst_in,      // Synchronous reset
  input  wire logic       run_in,      // Clocks running
  input  wire logic [1:0] div_in,      // Clock divide code
  output logic            tick_out,    // Last clock of a machine cycle
  output logic            fourth_out   // Start of fourth state
);
  logic [CPC_W-1:0] cnt_reg;
  logic [CPC_W-1:0] last;
  logic [CPC_W-1:0] c4_at;

  // Cycle length and fourth-state position per divide code
  always_comb begin
    case (div_in)
      DIV_64:   last = CPC_W'(CPC_64 - 1);
      DIV_1024: last = CPC_W'(CPC_1024 - 1);
      default:  last = CPC_W'(CPC_4 - 1);
    endcase
    c4_at = last - (last >> 2);
  end

  // Clock counter within the machine cycle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !run_in) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CPC_W'(1);
    end
  end

  // Registered strobes, one clock ahead of the counter value
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !run_in) begin
      tick_out   <= 1'b0;
      fourth_out <= 1'b0;
    end else begin
      tick_out   <= (cnt_reg == last - CPC_W'(1));
      fourth_out <= (cnt_reg + CPC_W'(1) == c4_at);
    end
  end

  AST_TICK_ONE_CLK: assert property (@(posedge sys_clk_in)
    disable iff (rst_in) tick_out |=> !tick_out)
    else $error("machine tick lasted more than one clock");
endmodule

// File: tb/cpu_pin_model.sv
// Pin-side partner: external reset pin, receive line and interrupt pins
`timescale 1ns/1ns
module cpu_pin_model #(
  parameter int IRQ_N = 2  // External interrupt pins
) (
  input  wire logic             sys_clk_in,   // System clock
  output logic                  rst_pin_out,  // Reset pin level
  output logic                  rx_line_out,  // Receive line, idles high
  output logic [IRQ_N-1:0]      irq_n_out     // Interrupt pins, pulled up
);
  // Idle levels: reset low, line idle, interrupt pins released to pull-up
  initial begin
    rst_pin_out = 1'b0;
    rx_line_out = 1'b1;
    irq_n_out   = '1;
  end

  // Hold the reset pin high for a given number of clocks, with no minimum enforced
  task automatic reset_pulse(input int clks);
    @(posedge sys_clk_in);
    rst_pin_out <= 1'b1;
    repeat (clks) @(posedge sys_clk_in);
    rst_pin_out <= 1'b0;
  endtask

  // Start bit: a falling edge, a low bit time, then back to idle
  task automatic start_bit(input int clks);
    @(posedge sys_clk_in);
    rx_line_out <= 1'b0;
    repeat (clks) @(posedge sys_clk_in);
    rx_line_out <= 1'b1;
  endtask

  // Drive a pin to the given level on the next clock: low to assert it, high to release it
  task automatic irq_drive(input int idx, input logic lvl);
    @(posedge sys_clk_in);
    irq_n_out[idx] <= lvl;
  endtask
endmodule

// File: tb/tb.sv
// Self-checking testbench for the clock, power and reset controller
`timescale 1ns/1ns
module tb;
  import clk_pwr_pkg::*;
  localparam int IRQ_N = 2;
  localparam int XTAL_WARM = 16;
  logic             sys_clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic [6:0]       pulses = 7'h00;
  logic [1:0]       div_sel_in = DIV_4;
  logic             switchback_enable_in = 1'b0, serial_rx_en_in = 1'b0;
  logic             clock_source_select_in = 1'b1, crystal_amp_off_in = 1'b0;
  logic             rc_wake_select_in = 1'b0, serial_busy_in = 1'b0;
  logic             irq_blocked_in = 1'b0, global_irq_enable_in = 1'b0;
  logic             ext_prog_mem_in = 1'b0, wdt_rst_en_in = 1'b0;
  logic [IRQ_N-1:0] irq_enable_in = '0, irq_level_in = '0, ext_irq_n_in;
  wire logic        rst_pin_in, serial_rx_in;
  logic [1:0]       div_code_out;
  logic             rc_active_status_out, crystal_ready_flag_out;
  logic             crystal_amp_en_out, clocks_run_out, strobes_low_out;
  logic             port0_float_out, sys_reset_out, restart_zero_out;
  logic             wake_irq_out, exp_rc, machine_tick_out, fourth_state_out;
  logic [1:0]       seq [8] = '{2'h2, 2'h3, 2'h1, 2'h3,
                                2'h2, 2'h1, 2'h0, 2'h2};
  int               failures = 0, n_compared = 0, model_div = 1;
  int               n_tick = 0, n_fourth = 0;
  int               n_restart = 0, n_wake = 0, n, r0, w0;

  initial forever #4 sys_clk_in = ~sys_clk_in;

  clock_power_reset_control #(.XTAL_WARM(XTAL_WARM), .IRQ_N(IRQ_N))
    i_clock_power_reset_control (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .rst_pin_in(rst_pin_in),
    .div_wr_in(pulses[6]), .div_sel_in(div_sel_in),
    .switchback_enable_in(switchback_enable_in), .src_wr_in(pulses[2]),
    .clock_source_select_in(clock_source_select_in),
    .crystal_amp_off_in(crystal_amp_off_in),
    .rc_wake_select_in(rc_wake_select_in),
    .serial_rx_en_in(serial_rx_en_in), .serial_rx_in(serial_rx_in),
    .sbuf_wr_in(pulses[0]), .serial_busy_in(serial_busy_in),
    .irq_ack_in(pulses[1]), .irq_blocked_in(irq_blocked_in),
    .ext_irq_n_in(ext_irq_n_in), .irq_enable_in(irq_enable_in),
    .irq_level_in(irq_level_in),
    .global_irq_enable_in(global_irq_enable_in),
    .ext_prog_mem_in(ext_prog_mem_in), .power_down_wr_in(pulses[3]),
    .wdt_rst_en_in(wdt_rst_en_in), .wdt_timeout_in(pulses[4]),
    .wdt_clear_in(pulses[5]), .div_code_out(div_code_out),
    .machine_tick_out(machine_tick_out),
    .fourth_state_out(fourth_state_out),
    .rc_active_status_out(rc_active_status_out),
    .crystal_ready_flag_out(crystal_ready_flag_out),
    .crystal_amp_en_out(crystal_amp_en_out),
    .clocks_run_out(clocks_run_out), .strobes_low_out(strobes_low_out),
    .port0_float_out(port0_float_out), .sys_reset_out(sys_reset_out),
    .restart_zero_out(restart_zero_out), .wake_irq_out(wake_irq_out));

  cpu_pin_model #(.IRQ_N(IRQ_N)) i_cpu_pin_model (
    .sys_clk_in(sys_clk_in), .rst_pin_out(rst_pin_in),
    .rx_line_out(serial_rx_in), .irq_n_out(ext_irq_n_in));

  // Count one-cycle restart and wake pulses
  always @(posedge sys_clk_in) begin
    if (restart_zero_out === 1'b1) n_restart++;
    if (wake_irq_out === 1'b1) n_wake++;
    if (machine_tick_out === 1'b1) n_tick++;
    if (fourth_state_out === 1'b1) n_fourth++;
  end

  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [1:0] probe(input int sel);
    case (sel)
      0: probe = div_code_out;
      1: probe = {1'b0, sys_reset_out};
      2: probe = {1'b0, clocks_run_out};
      3: probe = {1'b0, rc_active_status_out};
      4: probe = {1'b0, crystal_ready_flag_out};
      default: probe = {1'b0, crystal_amp_en_out};
    endcase
  endfunction

  // Bounded wait for an output to reach a value, then compare
  task automatic await(input int sel, input logic [1:0] exp, input int lim);
    int k;
    k = 0;
    while (probe(sel) !== exp && k < lim) begin
      @(posedge sys_clk_in);
      k++;
    end
    check(probe(sel), exp);
    if (probe(sel) !== exp) test_done();
  endtask

  // One-cycle request pulse on a chosen strobe input
  task automatic strobe(input int w);
    @(posedge sys_clk_in);
    pulses[w] <= 1'b1;
    @(posedge sys_clk_in);
    pulses <= 7'h00;
  endtask

  function automatic int cpc(input int d);
    return d == 3 ? CPC_1024 : d == 2 ? CPC_64 : CPC_4;
  endfunction

  // Divide write through the model: reserved, slow-to-slow, busy refused
  task automatic write_div(input logic [1:0] v);
    int c;
    c = cpc(model_div);
    if (v != 0 && !(switchback_enable_in && serial_busy_in) &&
        (model_div == 1 || v == 1))
      model_div = v;
    div_sel_in <= v;
    strobe(6);
    repeat (c + 3) @(posedge sys_clk_in);
    check(div_code_out, model_div[1:0]);
  endtask

  initial begin
    void'($urandom(32'hE984285E));
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    await(1, 2'h0, 20);
    check(div_code_out, DIV_RST);
    // Machine cycle strobes at divide-by-4
    n = n_tick;
    r0 = n_fourth;
    repeat (10 * CPC_4) @(posedge sys_clk_in);
    check(n_tick - n, 10);
    check(n_fourth - r0, 10);
    foreach (seq[i]) write_div(seq[i]);
    // Switchback on transmit, receive start bit and taken interrupt
    switchback_enable_in <= 1'b1;
    strobe(0);
    model_div = 1;
    await(0, DIV_4, 4);
    write_div(2'h3);
    i_cpu_pin_model.start_bit(8);
    check(div_code_out, DIV_1024);
    serial_rx_en_in <= 1'b1;
    i_cpu_pin_model.start_bit(8);
    model_div = 1;
    await(0, DIV_4, 4);
    write_div(2'h2);
    global_irq_enable_in <= 1'b1;
    irq_blocked_in <= 1'b1;
    strobe(1);
    repeat (4) @(posedge sys_clk_in);
    check(div_code_out, DIV_64);
    irq_blocked_in <= 1'b0;
    strobe(1);
    model_div = 1;
    await(0, DIV_4, 4);
    serial_busy_in <= 1'b1;
    @(posedge sys_clk_in);
    write_div(2'h3);
    serial_busy_in <= 1'b0;
    // Oscillator source, crystal amplifier and ready flag
    clock_source_select_in <= 1'b0;
    strobe(2);
    await(3, 2'h1, 8);
    crystal_amp_off_in <= 1'b1;
    await(5, 2'h0, 8);
    crystal_amp_off_in <= 1'b0;
    clock_source_select_in <= 1'b1;
    exp_rc = 1'b1;
    strobe(2);
    repeat (8) @(posedge sys_clk_in);
    check(rc_active_status_out, exp_rc);
    await(4, 2'h1, XTAL_WARM + 16);
    strobe(2);
    await(3, 2'h0, 8);
    // Power-down, interrupt wake on RC, then automatic move to crystal
    ext_prog_mem_in <= 1'($urandom);
    irq_enable_in <= 2'h1;
    irq_level_in <= 2'h1;
    rc_wake_select_in <= 1'b1;
    strobe(3);
    await(2, 2'h0, 4);
    check(strobes_low_out, 1'b1);
    check(port0_float_out, ext_prog_mem_in);
    w0 = n_wake;
    i_cpu_pin_model.irq_drive(0, 1'b0);
    await(2, 2'h1, 8);
    check(rc_active_status_out, 1'b1);
    repeat (2) @(posedge sys_clk_in);
    check(n_wake - w0, 1);
    i_cpu_pin_model.irq_drive(0, 1'b1);
    await(3, 2'h0, XTAL_WARM + 24);
    // Interrupt wake on the crystal waits for warm-up
    rc_wake_select_in <= 1'b0;
    strobe(3);
    await(2, 2'h0, 4);
    w0 = n_wake;
    i_cpu_pin_model.irq_drive(0, 1'b0);
    repeat (4) @(posedge sys_clk_in);
    check(clocks_run_out, 1'b0);
    await(2, 2'h1, XTAL_WARM + 8);
    check(rc_active_status_out, 1'b0);
    repeat (2) @(posedge sys_clk_in);
    check(n_wake - w0, 1);
    i_cpu_pin_model.irq_drive(0, 1'b1);
    // Power-down left through the reset pin
    strobe(3);
    await(2, 2'h0, 4);
    r0 = n_restart;
    i_cpu_pin_model.reset_pulse(8 + $urandom_range(8));
    check(sys_reset_out, 1'b1);
    await(1, 2'h0, 24);
    repeat (2) @(posedge sys_clk_in);
    check(n_restart - r0, 1);
    check(clocks_run_out, 1'b1);
    // Running reset from the slow rate forces divide-by-4
    write_div(2'h2);
    i_cpu_pin_model.reset_pulse(2 * CPC_64 + 4);
    check(sys_reset_out, 1'b1);
    model_div = 1;
    await(1, 2'h0, 3 * CPC_64);
    check(div_code_out, DIV_4);
    // Watchdog reset after the timeout flag, and a cleared watchdog
    wdt_rst_en_in <= 1'b1;
    strobe(4);
    n = 0;
    while (sys_reset_out !== 1'b1 && n < 600) begin
      @(posedge sys_clk_in);
      n++;
    end
    check(n >= WDT_DELAY_CLKS - 1 && n <= WDT_DELAY_CLKS + 2, 1'b1);
    await(1, 2'h0, 4 * CPC_4);
    strobe(4);
    repeat (100) @(posedge sys_clk_in);
    strobe(5);
    repeat (600) @(posedge sys_clk_in);
    check(sys_reset_out, 1'b0);
    test_done();
  end
endmodule
